// File: timer_pwm_carrier_map.svh
// Functional notes
// - PWM start skips first count clock; output stays inactive until first period match.
// - Duty write while running is buffered, moved in at old duty match.
// - Buffered value needs three count clocks before any transfer.
// - PWM period match clears counter, drives output active, raises interrupt.
// - PWM duty match drives output inactive only; no clear, no interrupt.
// - Clearing run enable forces interrupt and output inactive.
// - Carrier mode: low compare sets low phase, high compare sets high phase.
// - Carrier pin: enable 0 follows gate; enable 1 gives carrier gated by gate.
// - Gate is master/slave pair; active bit read-only, buffer bit read/write.
// - Envelope interrupt synchronised to count clock forms strobe copying gate.
// - Gate copy happens on second count clock after strobe rising edge.
// - Carrier starts on low compare; each match interrupts, clears, inverts, swaps.
// - Carrier period is N+M+2 count clocks, high phase M+1.
// - Carrier starts at inactive level when run enable is set.
// - Gate high: pulses begin at next carrier rise; gate low: output low.
// - Gate dropping during high phase never shortens the high pulse.
// - High compare rewrite while running takes effect after old value match.
// - PWM period N+1 count clocks, active width M+1.
`ifndef TIMER_PWM_CARRIER_MAP_SVH
`define TIMER_PWM_CARRIER_MAP_SVH
`define CNT_RESET 8'h00
`define CMP_RESET 8'h00
`define MIN_XFER_TICKS 2'h3
`define GATE_XFER_TICKS 2'h2
`define GATE_RESET 1'b0
`endif

// File: timer_pwm_carrier_pkg.sv
package timer_pwm_carrier_pkg;
   typedef enum logic {CMP_FIRST, CMP_SECOND} cmp_sel_t;
endpackage

// File: timer_pwm_carrier_gen.sv
`timescale 1ns/1ps
`include "timer_pwm_carrier_map.svh"
module timer_pwm_carrier_gen
   import timer_pwm_carrier_pkg::*;
#(
   parameter int WIDTH = 8,
   parameter bit CARRIER_EN = 1'b1
)
(
   // Clock, reset, freeze
   input wire logic mclk,
   input wire logic nrst,
   input wire logic clk_en,
   // Count clock strobe, same domain
   input wire logic count_tick,
   // Control
   input wire logic timer_run_enable,
   input wire logic carrier_mode,
   input wire logic output_level_select,
   input wire logic remote_output_enable,
   // First compare: period, or carrier low width
   input wire logic [WIDTH-1:0] period_compare,
   // Second compare write, asynchronous toggle with stable data
   input wire logic [WIDTH-1:0] cmp1_wdata,
   input wire logic cmp1_wr_toggle,
   // Gate buffer write, same domain
   input wire logic gate_wdata,
   input wire logic gate_wr,
   // Envelope timer event, asynchronous
   input wire logic envelope_timer_irq,
   // Outputs
   output logic timer_output_pin,
   output logic carrier_output_pin,
   output logic compare_match_irq,
   output logic envelope_sync_strobe,
   output logic carrier_gate_active,
   output logic carrier_gate_buffer,
   output logic [WIDTH-1:0] duty_compare,
   output logic [WIDTH-1:0] count_value
);

   generate
      if (WIDTH != 8)
      begin : g_chk
         $error("timer_pwm_carrier_gen supports WIDTH 8 only");
      end
   endgenerate

   logic run_q;
   logic skip_q;
   cmp_sel_t sel_q;
   logic act_q;
   logic cen_q;
   logic [WIDTH-1:0] cnt_q;
   logic [WIDTH-1:0] buf_q;
   logic pend_q;
   logic [1:0] age_q;
   logic [WIDTH-1:0] wd1_q;
   logic [WIDTH-1:0] wd2_q;
   logic wt1_q;
   logic wt2_q;
   logic wt3_q;
   logic es1_q;
   logic es2_q;
   logic es3_q;
   logic env_pend_q;
   logic [1:0] gx_q;

   // Decode
   wire tick_w = count_tick & clk_en;
   wire run_w = timer_run_enable & run_q;
   wire start_w = clk_en & timer_run_enable & ~run_q;
   wire car_w = carrier_mode & CARRIER_EN;
   wire [WIDTH-1:0] cmp_w = (sel_q == CMP_FIRST) ? period_compare : duty_compare;
   wire hit_w = tick_w & run_w & ~skip_q & (cnt_q == cmp_w);
   wire clr_w = hit_w & (car_w | (sel_q == CMP_FIRST));
   wire wr_w = clk_en & (wt2_q ^ wt3_q);
   wire xfer_w = hit_w & (sel_q == CMP_SECOND) & pend_q & (age_q >= `MIN_XFER_TICKS) & ~wr_w;
   wire env_rise_w = es2_q & ~es3_q;
   wire srise_w = tick_w & (env_pend_q | env_rise_w) & ~envelope_sync_strobe;
   wire gcopy_w = tick_w & (gx_q == `GATE_XFER_TICKS);

   // Next carrier / output level
   logic act_d;
   always_comb
   begin
      act_d = act_q;
      if (!run_w)
         act_d = 1'b0;
      else if (hit_w)
         act_d = car_w ? ~act_q : (sel_q == CMP_FIRST);
   end

   // Output enable latch for the carrier
   logic cen_d;
   always_comb
   begin
      cen_d = cen_q;
      if (!run_w || !car_w)
         cen_d = 1'b0;
      else if (act_d && !act_q && carrier_gate_active)
         cen_d = 1'b1;
      else if (!carrier_gate_active && !act_d)
         cen_d = 1'b0;
   end

   wire cpin_d = remote_output_enable ? (cen_d & act_d) : carrier_gate_active;
   wire pin_d = (~car_w & act_d) ^ output_level_select;
   wire [WIDTH-1:0] cnt_d = !run_w ? `CNT_RESET :
                            (tick_w && !skip_q) ? (clr_w ? `CNT_RESET : cnt_q + 8'h01) : cnt_q;

   // Run tracking and first-tick mask
   always_ff @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
      begin
         run_q <= 1'b0;
         skip_q <= 1'b0;
      end
      else if (clk_en)
      begin
         run_q <= timer_run_enable;
         if (start_w)
            skip_q <= ~car_w;
         else if (tick_w)
            skip_q <= 1'b0;
      end
   end

   // Counter and compare selection
   always_ff @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
      begin
         cnt_q <= `CNT_RESET;
         sel_q <= CMP_FIRST;
      end
      else if (clk_en)
      begin
         cnt_q <= cnt_d;
         if (!run_w)
            sel_q <= CMP_FIRST;
         else if (hit_w)
            sel_q <= (sel_q == CMP_FIRST) ? CMP_SECOND : CMP_FIRST;
      end
   end

   // Registered outputs
   always_ff @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
      begin
         act_q <= 1'b0;
         cen_q <= 1'b0;
         compare_match_irq <= 1'b0;
         timer_output_pin <= 1'b0;
         carrier_output_pin <= 1'b0;
      end
      else if (clk_en)
      begin
         act_q <= act_d;
         cen_q <= cen_d;
         compare_match_irq <= clr_w;
         timer_output_pin <= pin_d;
         carrier_output_pin <= cpin_d;
      end
   end

   // Compare write crossing; data settles before its toggle
   always_ff @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
      begin
         wd1_q <= `CMP_RESET;
         wd2_q <= `CMP_RESET;
         wt1_q <= 1'b0;
         wt2_q <= 1'b0;
         wt3_q <= 1'b0;
      end
      else if (clk_en)
      begin
         wd1_q <= cmp1_wdata;
         wd2_q <= wd1_q;
         wt1_q <= cmp1_wr_toggle;
         wt2_q <= wt1_q;
         wt3_q <= wt2_q;
      end
   end

   // Second compare: buffer, age, transfer
   always_ff @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
      begin
         buf_q <= `CMP_RESET;
         duty_compare <= `CMP_RESET;
         pend_q <= 1'b0;
         age_q <= 2'h0;
      end
      else if (wr_w)
      begin
         buf_q <= wd2_q;
         age_q <= 2'h0;
         pend_q <= run_w;
         if (!run_w)
            duty_compare <= wd2_q;
      end
      else if (xfer_w)
      begin
         duty_compare <= buf_q;
         pend_q <= 1'b0;
      end
      else if (tick_w && age_q != `MIN_XFER_TICKS)
         age_q <= age_q + 2'h1;
   end

   // Envelope crossing; the edge is taken from the second and third stages
   always_ff @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
      begin
         es1_q <= 1'b0;
         es2_q <= 1'b0;
         es3_q <= 1'b0;
      end
      else if (clk_en)
      begin
         es1_q <= envelope_timer_irq;
         es2_q <= es1_q;
         es3_q <= es2_q;
      end
   end

   // Strobe on count clock; gate master/slave copy
   always_ff @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
      begin
         env_pend_q <= 1'b0;
         envelope_sync_strobe <= 1'b0;
         gx_q <= 2'h0;
         carrier_gate_buffer <= `GATE_RESET;
         carrier_gate_active <= `GATE_RESET;
      end
      else if (clk_en)
      begin
         // An edge between ticks is held, never lost
         if (env_rise_w)
            env_pend_q <= ~tick_w;
         else if (tick_w)
            env_pend_q <= 1'b0;
         if (tick_w)
            envelope_sync_strobe <= env_pend_q | env_rise_w;
         if (srise_w)
            gx_q <= 2'h1;
         else if (gcopy_w)
            gx_q <= 2'h0;
         else if (tick_w && gx_q != 2'h0)
            gx_q <= gx_q + 2'h1;
         if (gcopy_w)
            carrier_gate_active <= carrier_gate_buffer;
         if (gate_wr)
            carrier_gate_buffer <= gate_wdata;
      end
   end

   assign count_value = cnt_q;

   // Ticks since the strobe rose; helper for the copy check only
   logic [1:0] tk_q;
   always_ff @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
         tk_q <= 2'h0;
      else if (srise_w)
         tk_q <= 2'h0;
      else if (tick_w && tk_q != 2'h3)
         tk_q <= tk_q + 2'h1;
   end

   // Checks
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!nrst);

   sequence s_strobe_rise;
      srise_w;
   endsequence

   sequence s_copy_second;
      gcopy_w && tk_q == 2'h1;
   endsequence

   skip_first_a: assert property (clk_en && skip_q && tick_w && run_w |=> cnt_q == 8'h00)
      else $error("first count clock not masked");

   start_idle_a: assert property (start_w && !car_w |=> timer_output_pin == output_level_select)
      else $error("output active at start");

   duty_hold_a: assert property (clk_en && run_w && pend_q && !xfer_w && !wr_w |=> $stable(duty_compare))
      else $error("duty changed without match");

   xfer_age_a: assert property (xfer_w |-> age_q == 2'h3 && pend_q)
      else $error("transfer before three count clocks");

   period_hit_a: assert property (hit_w && !car_w && sel_q == CMP_FIRST |=> cnt_q == 8'h00 && compare_match_irq && act_q)
      else $error("period match effects missing");

   duty_hit_a: assert property (hit_w && !car_w && sel_q == CMP_SECOND |=> !compare_match_irq && !act_q && cnt_q != 8'h00)
      else $error("duty match misbehaved");

   stop_idle_a: assert property (clk_en && !timer_run_enable |=> !compare_match_irq && !act_q)
      else $error("stop did not idle outputs");

   carrier_hit_a: assert property (hit_w && car_w |=> compare_match_irq && cnt_q == 8'h00 && act_q != $past(act_q))
      else $error("carrier match effects missing");

   gate_copy_a: assert property (s_strobe_rise |-> ##[1:100] s_copy_second)
      else $error("gate copy not on second count clock");

   gate_value_a: assert property (gcopy_w |=> carrier_gate_active == $past(carrier_gate_buffer))
      else $error("active gate not taken from buffer");

   pin_map_a: assert property (clk_en && !remote_output_enable |=> carrier_output_pin == $past(carrier_gate_active))
      else $error("carrier pin not following gate");

   high_keep_a: assert property (clk_en && remote_output_enable && carrier_output_pin && act_q && run_w && !hit_w
                                 |=> carrier_output_pin)
      else $error("carrier high pulse shortened");

endmodule

// File: envelope_event_src.sv
`timescale 1ns/1ps
module envelope_event_src
(
   // Request from bench
   input wire logic fire,
   // Event toward the timer
   output logic envelope_timer_irq
);
   initial envelope_timer_irq = 1'b0;
   // Slow, unaligned event; lasts many count clocks
   always @(posedge fire)
   begin
      #13 envelope_timer_irq = 1'b1;
      #600 envelope_timer_irq = 1'b0;
   end
endmodule

// File: timer_pwm_carrier_gen_test.sv
`timescale 1ns/1ps
module timer_pwm_carrier_gen_test;
   logic mclk, nrst, count_tick, run, cmode, ols, roe, tg, gate_wdata, gate_wr, fire, env_irq;
   logic [7:0] period_compare, cmp1_wdata, duty_compare, count_value;
   logic timer_output_pin, carrier_output_pin, compare_match_irq, envelope_sync_strobe;
   logic carrier_gate_active, carrier_gate_buffer;
   int errors, total_checks, h, p;

   timer_pwm_carrier_gen dut (.mclk(mclk), .nrst(nrst), .clk_en(1'b1), .count_tick(count_tick),
      .timer_run_enable(run), .carrier_mode(cmode), .output_level_select(ols),
      .remote_output_enable(roe), .period_compare(period_compare), .cmp1_wdata(cmp1_wdata),
      .cmp1_wr_toggle(tg), .gate_wdata(gate_wdata), .gate_wr(gate_wr), .envelope_timer_irq(env_irq),
      .timer_output_pin(timer_output_pin), .carrier_output_pin(carrier_output_pin),
      .compare_match_irq(compare_match_irq), .envelope_sync_strobe(envelope_sync_strobe),
      .carrier_gate_active(carrier_gate_active), .carrier_gate_buffer(carrier_gate_buffer),
      .duty_compare(duty_compare), .count_value(count_value));

   envelope_event_src env (.fire(fire), .envelope_timer_irq(env_irq));

   initial
   begin
      mclk = 1'b0;
      forever #12.5 mclk = ~mclk;
   end

   // One count clock every two mclk
   always @(posedge mclk) count_tick <= #1 ~count_tick;

   task automatic wrap_up;
      if (errors == 0 && total_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         errors++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask

   function automatic logic pin(input bit sel);
      return sel ? carrier_output_pin : timer_output_pin;
   endfunction

   // Counts cycles until the pin reaches lvl; a hang ends the run
   task automatic wait_lvl(input bit sel, input logic lvl, output int n);
      for (n = 0; n < 2000 && pin(sel) !== lvl; n++)
         cyc(1);
      if (n == 2000)
      begin
         errors++;
         wrap_up();
      end
   endtask

   task automatic measure(input bit sel, output int hi, output int per);
      int n, lo;
      wait_lvl(sel, 1'b0, n);
      wait_lvl(sel, 1'b1, n);
      wait_lvl(sel, 1'b0, hi);
      wait_lvl(sel, 1'b1, lo);
      per = hi + lo;
   endtask

   // Data held steady around the toggle, as the synchroniser needs
   task automatic write_cmp1(input logic [7:0] v);
      cmp1_wdata = v;
      cyc(4);
      tg = ~tg;
      cyc(4);
   endtask

   task automatic gate_event(input logic g);
      int i;
      logic seen;
      seen = 1'b0;
      gate_wdata = g;
      gate_wr = 1'b1;
      cyc(1);
      gate_wr = 1'b0;
      cyc(2);
      fire = 1'b1;
      cyc(1);
      fire = 1'b0;
      for (i = 0; i < 200 && carrier_gate_active !== g; i++)
      begin
         seen = seen | envelope_sync_strobe;
         cyc(1);
      end
      check(seen, 1'b1);
      check(carrier_gate_active, g);
      check(carrier_gate_buffer, g);
   endtask

   task automatic test_pwm;
      int i;
      period_compare = 8'h03;
      write_cmp1(8'h01);
      run = 1'b1;
      for (i = 0; i < 100 && compare_match_irq !== 1'b1; i++)
      begin
         check(timer_output_pin, 1'b0);
         cyc(1);
      end
      check(compare_match_irq, 1'b1);
      measure(1'b0, h, p);
      check(h, 16'd4);
      check(p, 16'd8);
      write_cmp1(8'h02);
      measure(1'b0, h, p);
      measure(1'b0, h, p);
      check(h, 16'd6);
      check(duty_compare, 8'h02);
      run = 1'b0;
      cyc(1);
      check(compare_match_irq, 1'b0);
      check(timer_output_pin, 1'b0);
      check(count_value, 8'h00);
   endtask

   task automatic test_carrier;
      cmode = 1'b1;
      ols = 1'b1;
      period_compare = 8'h02;
      roe = 1'b1;
      write_cmp1(8'h01);
      run = 1'b1;
      cyc(2);
      check(carrier_output_pin, 1'b0);
      gate_event(1'b1);
      measure(1'b1, h, p);
      check(h, 16'd4);
      check(p, 16'd10);
      check(timer_output_pin, 1'b1);
      roe = 1'b0;
      cyc(2);
      check(carrier_output_pin, 1'b1);
      gate_event(1'b0);
      cyc(2);
      check(carrier_output_pin, 1'b0);
   endtask

   initial
   begin
      errors = 0;
      total_checks = 0;
      {count_tick, run, cmode, ols, roe, tg, gate_wdata, gate_wr, fire} = '0;
      period_compare = 8'h00;
      cmp1_wdata = 8'h00;
      nrst = 1'b0;
      repeat (10) @(posedge mclk);
      #1 nrst = 1'b1;
      cyc(2);
      test_pwm();
      test_carrier();
      wrap_up();
   end
endmodule
